// file: verilog/secr_pkg.sv
// Package with register map, field positions, reset values and timing counts
package secr_pkg;
  localparam logic [6:0] ADDR_EXT_CFG = 7'h0B;
  localparam logic [6:0] ADDR_RES_LO = 7'h0C;
  localparam logic [6:0] ADDR_RES_HI = 7'h0D;
  localparam logic [6:0] ADDR_EXP_LO = 7'h0E;
  localparam logic [6:0] ADDR_EXP_HI = 7'h0F;
  localparam logic [6:0] ADDR_CFG_BITS = 7'h0A;
  localparam logic [6:0] ADDR_FP_MAX_LO = 7'h1A;
  localparam logic [6:0] ADDR_FP_MAX_HI = 7'h1B;
  localparam logic [6:0] ADDR_SH_MAX_LO = 7'h1E;
  localparam logic [6:0] ADDR_SH_MAX_HI = 7'h1F;
  localparam logic [6:0] ADDR_FW_CMD = 7'h14;
  localparam int BIT_BUSY = 7;
  localparam int BIT_ONE = 3;
  localparam int BIT_PULLUP_DIS = 2;
  localparam int BIT_AGC_DIS = 1;
  localparam int BIT_CONST_RATE = 0;
  localparam int BIT_SYS_TEST = 5;
  localparam logic [7:0] EXT_CFG_RST = 8'h08;
  localparam logic [15:0] EXPOSURE_RST = 16'h0085;
  localparam logic [15:0] FP_MAX_RST = 16'h2EE0;
  localparam logic [15:0] SH_MAX_RST = 16'h2000;
  localparam logic [15:0] SYS_TEST_PASS = 16'hA9D5;
  localparam logic [15:0] CRC_PASS = 16'hBEEF;
  localparam logic [7:0] CRC_START_CMD = 8'hA1;
  localparam int CLK_HZ = 25_000_000;
  localparam int SYS_TEST_MS = 200;
  localparam int SYS_TEST_CYC = SYS_TEST_MS * (CLK_HZ / 1000);
  localparam int CRC_TEST_MS = 7;
  localparam int CRC_TEST_CYC = CRC_TEST_MS * (CLK_HZ / 1000);
  localparam int BUSY_FRAMES = 2;
endpackage

// file: verilog/secr_regs.sv
// Exposure/config register slice behind a four-wire serial port
//
// Behaviour
// RQ1: Busy flag forbids bound writes when one
// RQ2: Host waits two frames after bound write
// RQ3: Pull-up disable bit turns port pull-ups off
// RQ4: AGC disable holds shutter at max bound
// RQ5: Constant rate uses max frame period bound
// RQ6: Self-test result pair reads A9 D5
// RQ7: CRC command yields BE EF result pair
// RQ8: System test started via configuration bits
// RQ9: Shutter read-only, upper byte read first
// RQ10: Shutter evaluated every frame in auto mode; frame ends while a self test or CRC test runs are skipped
// RQ11: Each adjustment changes shutter by one sixteenth
// RQ12: Host should pair AGC off with constant rate
// RQ13: Extended configuration bit three reads one
// RQ14: System test takes about two hundred milliseconds
// RQ15: CRC test command A1, wait 7 ms
`timescale 1ns/1ps
module secr_regs #(
  parameter int SYS_TEST_CYCLES = secr_pkg::SYS_TEST_CYC,
  parameter int CRC_TEST_CYCLES = secr_pkg::CRC_TEST_CYC
) (
  input wire logic clk, // Core clock, 25 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic sclkPin, // Serial clock from host
  input wire logic mosiPin, // Serial data from host
  input wire logic chipSelectN, // Chip select, active low
  output logic misoOut, // Serial data to host
  output logic misoOe, // MISO drive enable
  output logic pullupEnable, // Pull-up current sources on
  input wire logic frameTick, // One-cycle pulse at each frame end
  input wire logic [1:0] pixelLevel, // 0 too dark, 1 ok, 2 too bright
  input wire logic [15:0] autoFramePeriod, // Frame period from auto rate control
  output logic [15:0] framePeriod, // Frame period in use
  output logic [15:0] exposure, // Shutter value in use
  output logic testActive // Self test or CRC test running
);
  // Serial input synchronisers
  // Reset presets the idle levels, so no false edge follows reset
  logic [1:0] sclkSync_q;
  logic [1:0] mosiSync_q;
  logic [1:0] csSync_q;
  logic sclkPrev_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      sclkSync_q <= 2'b11;
      mosiSync_q <= 2'b00;
      csSync_q <= 2'b11;
      sclkPrev_q <= 1'b1;
    end else begin
      sclkSync_q <= {sclkSync_q[0], sclkPin};
      mosiSync_q <= {mosiSync_q[0], mosiPin};
      csSync_q <= {csSync_q[0], chipSelectN};
      sclkPrev_q <= sclkSync_q[1];
    end
  end
  wire logic csActive = ~csSync_q[1];
  wire logic sclkRise = csActive & sclkSync_q[1] & ~sclkPrev_q;
  wire logic sclkFall = csActive & ~sclkSync_q[1] & sclkPrev_q;

  // Serial frame: bit 7 of first byte is write flag, 7-bit address, then data byte
  logic [3:0] bitCnt_q;
  logic phaseData_q;
  logic isWrite_q;
  logic [6:0] addr_q;
  logic [7:0] shiftIn_q;
  logic [7:0] shiftOut_q;
  logic wrStrobe_q;
  logic [7:0] wrData_q;
  logic rdStrobe_q;
  logic [7:0] readByte;

  always_ff @(posedge clk) begin
    // Dropping chip select abandons a half-shifted frame
    if (rst || !csActive) begin
      bitCnt_q <= 4'h0;
      phaseData_q <= 1'b0;
      isWrite_q <= 1'b0;
      addr_q <= 7'h00;
      shiftIn_q <= 8'h00;
      wrStrobe_q <= 1'b0;
      wrData_q <= 8'h00;
      rdStrobe_q <= 1'b0;
    end else begin
      wrStrobe_q <= 1'b0;
      rdStrobe_q <= 1'b0;
      if (sclkRise) begin
        shiftIn_q <= {shiftIn_q[6:0], mosiSync_q[1]};
        if (bitCnt_q == 4'h7) begin
          bitCnt_q <= 4'h0;
          if (!phaseData_q) begin
            phaseData_q <= 1'b1;
            isWrite_q <= shiftIn_q[6];
            addr_q <= {shiftIn_q[5:0], mosiSync_q[1]};
            rdStrobe_q <= ~shiftIn_q[6];
          end else begin
            phaseData_q <= 1'b0;
            wrStrobe_q <= isWrite_q;
            wrData_q <= {shiftIn_q[6:0], mosiSync_q[1]};
          end
        end else begin
          bitCnt_q <= bitCnt_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shiftOut_q <= 8'h00;
      misoOut <= 1'b0;
      misoOe <= 1'b0;
    end else begin
      // Data out is driven only during the data byte of a read
      misoOe <= csActive & phaseData_q & ~isWrite_q;
      if (rdStrobe_q) begin
        shiftOut_q <= readByte;
        misoOut <= readByte[7];
      end else if (sclkFall && phaseData_q) begin
        // Each fall launches the next bit, MSB first, for the host to take on the following rise
        shiftOut_q <= {shiftOut_q[6:0], 1'b0};
        misoOut <= shiftOut_q[7];
      end
    end
  end

  // Register storage
  // Only the three writable configuration bits are stored
  logic [2:0] extCfg_q;
  logic [15:0] fpMax_q;
  logic [15:0] shMax_q;
  logic [15:0] result_q;
  logic [15:0] exposure_q;
  logic [7:0] exposureLoLatch_q;
  logic [1:0] busyFrames_q;
  logic [31:0] testCnt_q;
  logic sysTest_q;
  logic crcTest_q;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] ref_addr);
    hit = (a == ref_addr);
  endfunction

  // Register write decodes
  wire logic wrExt = wrStrobe_q & hit(addr_q, secr_pkg::ADDR_EXT_CFG);

  // Bound register decodes, shared by the write and busy logic
  wire logic hitFpLo = hit(addr_q, secr_pkg::ADDR_FP_MAX_LO);
  wire logic hitFpHi = hit(addr_q, secr_pkg::ADDR_FP_MAX_HI);
  wire logic hitShLo = hit(addr_q, secr_pkg::ADDR_SH_MAX_LO);
  wire logic hitShHi = hit(addr_q, secr_pkg::ADDR_SH_MAX_HI);
  wire logic wrBound = wrStrobe_q & (hitFpLo | hitFpHi | hitShLo | hitShHi);

  // Last cycle of the system test; the test wipes the register settings
  wire logic sysDone = sysTest_q & (testCnt_q == 32'h0000_0001);

  always_ff @(posedge clk) begin
    if (rst) begin
      extCfg_q <= secr_pkg::EXT_CFG_RST[2:0];
    end else if (sysDone) begin
      extCfg_q <= secr_pkg::EXT_CFG_RST[2:0]; // see RQ8
    end else if (wrExt) begin
      extCfg_q <= wrData_q[2:0];
    end
  end

  // Bound registers; writes ignored while busy
  always_ff @(posedge clk) begin
    if (rst) begin
      fpMax_q <= secr_pkg::FP_MAX_RST;
      shMax_q <= secr_pkg::SH_MAX_RST;
    end else if (sysDone) begin
      fpMax_q <= secr_pkg::FP_MAX_RST; // see RQ8
      shMax_q <= secr_pkg::SH_MAX_RST;
    end else if (wrBound && busyFrames_q == 2'd0) begin // see RQ2
      if (hitFpLo) fpMax_q[7:0] <= wrData_q;
      if (hitFpHi) fpMax_q[15:8] <= wrData_q;
      if (hitShLo) shMax_q[7:0] <= wrData_q;
      if (hitShHi) shMax_q[15:8] <= wrData_q;
    end
  end

  // Busy stays up for two frame ends after the upper max frame period write
  always_ff @(posedge clk) begin
    if (rst) begin
      busyFrames_q <= 2'd0;
    end else if (sysDone) begin
      busyFrames_q <= 2'd0; // see RQ8
    end else if (wrStrobe_q && hitFpHi && busyFrames_q == 2'd0) begin
      busyFrames_q <= 2'(secr_pkg::BUSY_FRAMES); // see RQ1
    end else if (frameTick && busyFrames_q != 2'd0) begin
      busyFrames_q <= busyFrames_q - 2'd1;
    end
  end

  // Self test and CRC test sequencing
  // A start while either test runs is ignored; the host keeps off the port meanwhile
  always_ff @(posedge clk) begin
    if (rst) begin
      sysTest_q <= 1'b0;
      crcTest_q <= 1'b0;
      testCnt_q <= 32'h0000_0000;
      result_q <= 16'h0000;
    end else if (sysTest_q || crcTest_q) begin
      if (testCnt_q == 32'h0000_0001) begin
        sysTest_q <= 1'b0;
        crcTest_q <= 1'b0;
        // Results appear only once the test has run its full length
        result_q <= sysTest_q ? secr_pkg::SYS_TEST_PASS : secr_pkg::CRC_PASS; // see RQ6 RQ7
      end
      testCnt_q <= testCnt_q - 32'h0000_0001;
    end else if (wrStrobe_q && hit(addr_q, secr_pkg::ADDR_CFG_BITS) && wrData_q[secr_pkg::BIT_SYS_TEST]) begin
      sysTest_q <= 1'b1; // see RQ8
      testCnt_q <= 32'(SYS_TEST_CYCLES); // see RQ14
    end else if (wrStrobe_q && hit(addr_q, secr_pkg::ADDR_FW_CMD) && wrData_q == secr_pkg::CRC_START_CMD) begin
      crcTest_q <= 1'b1; // see RQ15
      testCnt_q <= 32'(CRC_TEST_CYCLES);
    end
  end

  // Automatic exposure: step by one sixteenth per frame, or hold the bound
  logic [15:0] expStep;
  logic [15:0] exposure_d;
  always_comb begin
    expStep = (exposure_q[15:4] == 12'h000) ? 16'h0001 : {4'h0, exposure_q[15:4]};
    exposure_d = exposure_q;
    if (extCfg_q[secr_pkg::BIT_AGC_DIS]) begin
      exposure_d = shMax_q; // see RQ4
    end else if (frameTick && !testActive) begin // see RQ10
      case (pixelLevel)
        2'd0: begin
          // Brighten, but never past the shutter bound
          if (shMax_q >= expStep && exposure_q <= shMax_q - expStep) begin
            exposure_d = exposure_q + expStep; // see RQ11
          end else begin
            exposure_d = shMax_q;
          end
        end
        2'd2: begin
          // Darken, keeping the shutter above zero
          if (exposure_q > expStep) begin
            exposure_d = exposure_q - expStep; // see RQ11
          end
        end
        default: begin
          exposure_d = exposure_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      exposure_q <= secr_pkg::EXPOSURE_RST;
    end else begin
      exposure_q <= exposure_d;
    end
  end

  // Upper byte read latches the lower byte so the pair is coherent
  always_ff @(posedge clk) begin
    if (rst) begin
      exposureLoLatch_q <= secr_pkg::EXPOSURE_RST[7:0];
    end else if (rdStrobe_q && hit(addr_q, secr_pkg::ADDR_EXP_HI)) begin
      exposureLoLatch_q <= exposure_q[7:0]; // see RQ9
    end
  end

  always_comb begin
    // Reserved and unmapped bits read as zero
    readByte = 8'h00;
    case (addr_q)
      secr_pkg::ADDR_EXT_CFG: begin
        readByte[secr_pkg::BIT_BUSY] = (busyFrames_q != 2'd0); // see RQ1
        readByte[secr_pkg::BIT_ONE] = 1'b1; // see RQ13
        readByte[2:0] = extCfg_q;
      end
      secr_pkg::ADDR_RES_LO: readByte = result_q[7:0];
      secr_pkg::ADDR_RES_HI: readByte = result_q[15:8];
      secr_pkg::ADDR_EXP_LO: readByte = exposureLoLatch_q;
      secr_pkg::ADDR_EXP_HI: readByte = exposure_q[15:8];
      default: readByte = 8'h00;
    endcase
  end

  // Outputs from flip-flops
  always_ff @(posedge clk) begin
    if (rst) begin
      pullupEnable <= 1'b1;
      framePeriod <= secr_pkg::FP_MAX_RST;
      exposure <= secr_pkg::EXPOSURE_RST;
      testActive <= 1'b0;
    end else begin
      // Pull-up sources stay on unless the disable bit is set
      pullupEnable <= ~extCfg_q[secr_pkg::BIT_PULLUP_DIS]; // see RQ3
      framePeriod <= extCfg_q[secr_pkg::BIT_CONST_RATE] ? fpMax_q : autoFramePeriod; // see RQ5
      exposure <= exposure_q;
      testActive <= sysTest_q | crcTest_q;
    end
  end
endmodule

// file: tb/secr_chk.sv
// Port-level assertions for the exposure and configuration register slice
`timescale 1ns/1ps
module secr_chk #(
  parameter int SYS_TEST_CYCLES = 50,
  parameter int CRC_TEST_CYCLES = 50
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Sync reset
  input wire logic sclkPin, // Serial clock
  input wire logic chipSelectN, // Chip select
  input wire logic misoOut, // Serial data out
  input wire logic misoOe, // Data out enable
  input wire logic pullupEnable, // Pull-ups on
  input wire logic frameTick, // Frame end pulse
  input wire logic [1:0] pixelLevel, // Brightness class
  input wire logic [15:0] exposure, // Shutter value
  input wire logic testActive // Test running
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic sclkQ;
  logic [3:0] sinceEdge, sinceRise, sinceTick;
  int activeCnt;
  // Saturating ages of the last serial clock edge, rise and frame tick
  always_ff @(posedge clk) begin
    sclkQ <= sclkPin;
    sinceEdge <= rst ? 4'hF : (sclkPin != sclkQ) ? 4'h0 : sinceEdge + {3'h0, sinceEdge != 4'hF};
    sinceRise <= rst ? 4'hF : (sclkPin && !sclkQ) ? 4'h0 : sinceRise + {3'h0, sinceRise != 4'hF};
    sinceTick <= rst ? 4'hF : frameTick ? 4'h0 : sinceTick + {3'h0, sinceTick != 4'hF};
    activeCnt <= testActive ? activeCnt + 1 : 0;
  end
  a_step_down: assert property (
    $changed(exposure) && sinceTick <= 4'd3 && pixelLevel == 2'd2 && $past(exposure) >= 16'h0010
    |-> exposure == $past(exposure) - ($past(exposure) >> 4)) else $error("shutter step down wrong");
  a_step_up: assert property (
    $changed(exposure) && sinceTick <= 4'd3 && pixelLevel == 2'd0 && $past(exposure) < 16'h1000
    |-> exposure == $past(exposure) + ($past(exposure) >> 4)) else $error("shutter step up wrong");
  a_level_hold: assert property (
    sinceTick <= 4'd3 && pixelLevel == 2'd1 |-> $stable(exposure)) else $error("shutter moved at good level");
  a_test_length: assert property (
    $fell(testActive) |-> activeCnt >= CRC_TEST_CYCLES - 2 && activeCnt <= SYS_TEST_CYCLES + 2)
    else $error("test duration wrong");
  a_test_start: assert property (
    $rose(testActive) |-> sinceRise <= 4'd8) else $error("test started without a write");
  a_pullup_write: assert property (
    $changed(pullupEnable) |-> sinceRise <= 4'd8) else $error("pull-up changed without a write");
  a_miso_idle: assert property (
    chipSelectN [*4] |-> !misoOe) else $error("data out driven while deselected");
  a_miso_edge: assert property (
    misoOe && $changed(misoOut) |-> sinceEdge <= 4'd8) else $error("data out moved between edges");
  c_dark: cover property (frameTick && pixelLevel == 2'd0);
  c_test: cover property ($fell(testActive));
  c_pullup: cover property ($fell(pullupEnable));
  c_read: cover property (misoOe && misoOut);
endmodule
bind secr_regs secr_chk #(.SYS_TEST_CYCLES(SYS_TEST_CYCLES), .CRC_TEST_CYCLES(CRC_TEST_CYCLES)) chkI (
  .clk(clk), .rst(rst), .sclkPin(sclkPin), .chipSelectN(chipSelectN), .misoOut(misoOut), .misoOe(misoOe),
  .pullupEnable(pullupEnable), .frameTick(frameTick), .pixelLevel(pixelLevel), .exposure(exposure),
  .testActive(testActive));

// file: tb/secr_host.sv
// Host microcontroller model driving the four-wire serial port
`timescale 1ns/1ps
module secr_host (
  input wire logic clk, // Core clock
  output logic sclk, // Serial clock, idles high
  output logic mosi, // Data to device
  output logic csN, // Chip select
  input wire logic miso, // Data from device
  input wire logic misoOe // Device drives data
);
  initial begin
    sclk = 1'b1;
    mosi = 1'b0;
    csN = 1'b1;
  end
  // Address byte then data byte; reads put a toggling filler on MOSI
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    logic [15:0] s;
    s = {a, d};
    r = 8'h00;
    @(negedge clk);
    csN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (4) @(negedge clk);
      sclk = 1'b0;
      mosi = (i < 8 && !a[7]) ? ~mosi : s[i];
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      if (i < 8) r[i] = misoOe ? miso : ~r[i];
    end
    repeat (4) @(negedge clk);
    csN = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the exposure and configuration register slice
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module testbench;
  logic clk, rst, sclk, mosi, csN, misoOut, misoOe, pullupEnable, frameTick, testActive;
  logic [1:0] pixelLevel;
  logic [15:0] autoFramePeriod, framePeriod, exposure;
  logic [7:0] r;
  int errors = 0;
  int samples_checked = 0;
  secr_regs #(.SYS_TEST_CYCLES(50), .CRC_TEST_CYCLES(50)) DUT (.clk(clk), .rst(rst), .sclkPin(sclk),
    .mosiPin(mosi), .chipSelectN(csN), .misoOut(misoOut), .misoOe(misoOe), .pullupEnable(pullupEnable),
    .frameTick(frameTick), .pixelLevel(pixelLevel), .autoFramePeriod(autoFramePeriod),
    .framePeriod(framePeriod), .exposure(exposure), .testActive(testActive));
  secr_host hostM (.clk(clk), .sclk(sclk), .mosi(mosi), .csN(csN), .miso(misoOut), .misoOe(misoOe));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    hostM.xfer({1'b0, a}, 8'h00, r);
    `CHK(r, e)
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    hostM.xfer({1'b1, a}, d, r);
  endtask
  task automatic tick();
    frameTick = 1'b1;
    @(negedge clk);
    frameTick = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic wait_idle();
    `CHK(testActive, 1'b1)
    for (int i = 0; i < 200 && testActive !== 1'b0; i++) @(negedge clk);
    `CHK(testActive, 1'b0)
  endtask
  task automatic t_reset();
    rd(secr_pkg::ADDR_EXT_CFG, secr_pkg::EXT_CFG_RST);
    rd(secr_pkg::ADDR_EXP_HI, 8'h00);
    rd(secr_pkg::ADDR_EXP_LO, 8'h85);
    rd(secr_pkg::ADDR_RES_HI, 8'h00);
    rd(7'h30, 8'h00);
    `CHK(pullupEnable, 1'b1)
    `CHK(framePeriod, 16'h1234)
    $display("test reset done");
  endtask
  task automatic t_agc();
    pixelLevel = 2'd0;
    rd(secr_pkg::ADDR_EXP_HI, 8'h00);
    tick();
    rd(secr_pkg::ADDR_EXP_LO, 8'h85);
    `CHK(exposure, 16'h008D)
    pixelLevel = 2'd2;
    tick();
    `CHK(exposure, 16'h0085)
    pixelLevel = 2'd1;
    tick();
    `CHK(exposure, 16'h0085)
    wr(secr_pkg::ADDR_EXT_CFG, 8'h0B);
    wr(secr_pkg::ADDR_SH_MAX_HI, 8'h03);
    `CHK(exposure, 16'h0300)
    `CHK(framePeriod, secr_pkg::FP_MAX_RST)
    $display("test agc done");
  endtask
  task automatic t_busy();
    wr(secr_pkg::ADDR_FP_MAX_HI, 8'h12);
    `CHK(framePeriod, 16'h12E0)
    rd(secr_pkg::ADDR_EXT_CFG, 8'h8B);
    wr(secr_pkg::ADDR_FP_MAX_LO, 8'hC0);
    `CHK(framePeriod, 16'h12E0)
    tick();
    tick();
    rd(secr_pkg::ADDR_EXT_CFG, 8'h0B);
    wr(secr_pkg::ADDR_FP_MAX_LO, 8'hC0);
    `CHK(framePeriod, 16'h12C0)
    $display("test busy done");
  endtask
  task automatic t_pullup();
    wr(secr_pkg::ADDR_EXT_CFG, 8'h0C);
    `CHK(pullupEnable, 1'b0)
    rd(secr_pkg::ADDR_EXT_CFG, 8'h0C);
    wr(secr_pkg::ADDR_EXT_CFG, 8'h08);
    `CHK(pullupEnable, 1'b1)
    $display("test pullup done");
  endtask
  task automatic t_tests();
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    wr(secr_pkg::ADDR_EXT_CFG, 8'h09);
    `CHK(framePeriod, secr_pkg::FP_MAX_RST)
    wr(secr_pkg::ADDR_CFG_BITS, 8'h28);
    wait_idle();
    `CHK(framePeriod, 16'h1234)
    rd(secr_pkg::ADDR_EXT_CFG, secr_pkg::EXT_CFG_RST);
    rd(secr_pkg::ADDR_RES_LO, 8'hD5);
    rd(secr_pkg::ADDR_RES_HI, 8'hA9);
    wr(secr_pkg::ADDR_FW_CMD, secr_pkg::CRC_START_CMD);
    wait_idle();
    rd(secr_pkg::ADDR_RES_HI, 8'hBE);
    rd(secr_pkg::ADDR_RES_LO, 8'hEF);
    $display("test self tests done");
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    frameTick = 1'b0;
    pixelLevel = 2'd1;
    autoFramePeriod = 16'h1234;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_agc();
    t_busy();
    t_pullup();
    t_tests();
    test_done();
  end
  initial begin
    repeat (20000) @(negedge clk);
    errors++;
    test_done();
  end
endmodule
